//--- src/ovcsc_top.sv
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
module ovcsc_top
  import ovcsc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [17:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Oscillator sources and sleep
  input  wire logic        slowOscillator,
  input  wire logic        fastOscillator,
  input  wire logic        sleep,
  // Oscillator and regulator control
  output logic             fastOscEnable,
  output logic      [1:0]  coreLevelSel,
  output ovcsc_volt_t      coreRegulatorVoltage,
  // CPU clock
  output logic             cpuClock,
  // Peripheral clock ticks
  output logic             timer0Tick,
  output logic             timer1Tick,
  output logic             timer2Tick,
  output logic             slowClockOut,
  output logic             fastClockOut
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Tick when the low k counter bits are all ones
  function automatic logic divTap(input logic [OVCSC_CNT_W-1:0] cnt,
                                  input logic [3:0] k);
    logic [OVCSC_CNT_W-1:0] mask;
    mask = ~({OVCSC_CNT_W{1'b1}} << k);
    return &(cnt | ~mask);
  endfunction

  // Fast ratio codes for the 16-bit timers: 2,8,32,64,128,256,1024,4096
  function automatic logic [3:0] fastExp(input logic [2:0] code);
    logic [3:0] e;
    e = 4'h1;
    unique case (code)
      3'h0: e = 4'h1;
      3'h1: e = 4'h3;
      3'h2: e = 4'h5;
      3'h3: e = 4'h6;
      3'h4: e = 4'h7;
      3'h5: e = 4'h8;
      3'h6: e = 4'ha;
      3'h7: e = 4'hc;
    endcase
    return e;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0] level_reg;
  logic [1:0] level_next;
  logic       osc_reg;
  logic       osc_next;
  logic       cpuSel_reg;
  logic       cpuSel_next;
  logic [4:0] ps_reg [5];
  logic [4:0] ps_next [5];
  logic       served_reg;
  logic       served_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        cpuOnFast;

  logic        req;
  logic        hit;
  logic [15:0] idx;

  assign req = read | write;
  assign idx = address[17:2];
  assign hit = (address[1:0] == 2'h0);

  // Bus access: one wait cycle, then the answer
  always_comb begin
    served_next = req & ~served_reg;
    waitrequest = req & ~served_reg;
    level_next  = level_reg;
    osc_next    = osc_reg;
    cpuSel_next = cpuSel_reg;
    for (int i = 0; i < 5; i++) begin
      ps_next[i] = ps_reg[i];
    end
    rdata_next = rdata_reg;
    if (read && !served_reg) begin
      rdata_next = 32'h0;
      if (hit) begin
        unique case (idx)
          OVCSC_IDX_CTRL:  rdata_next = {28'h0, cpuSel_reg, osc_reg,
                                         level_reg};
          OVCSC_IDX_PST0:  rdata_next = {27'h0, ps_reg[0]};
          OVCSC_IDX_PST1:  rdata_next = {27'h0, ps_reg[1]};
          OVCSC_IDX_PST2:  rdata_next = {27'h0, ps_reg[2]};
          OVCSC_IDX_SLOW_CLOCK_OUT: rdata_next = {27'h0, ps_reg[3]};
          OVCSC_IDX_FAST_CLOCK_OUT: rdata_next = {27'h0, ps_reg[4]};
          OVCSC_IDX_STAT:  rdata_next = {30'h0, osc_reg, cpuOnFast};
          default:         rdata_next = 32'h0;
        endcase
      end
    end
    if (write && served_reg && hit && byteenable[0]) begin
      unique case (idx)
        OVCSC_IDX_CTRL: begin
          level_next  = writedata[OVCSC_CTRL_LVL_HI:OVCSC_CTRL_LVL_LO];
          osc_next    = writedata[OVCSC_CTRL_OSC];
          cpuSel_next = writedata[OVCSC_CTRL_CPUSEL];
        end
        OVCSC_IDX_PST0:  ps_next[0] = writedata[4:0];
        OVCSC_IDX_PST1:  ps_next[1] = writedata[4:0];
        OVCSC_IDX_PST2:  ps_next[2] = {writedata[4], 1'b1, writedata[2:0]};
        OVCSC_IDX_SLOW_CLOCK_OUT: ps_next[3] = {writedata[4], 1'b0, writedata[2:0]};
        OVCSC_IDX_FAST_CLOCK_OUT: ps_next[4] = {writedata[4], 1'b1, writedata[2:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_reg  <= OVCSC_LVL_RST;
      osc_reg    <= OVCSC_OSC_RST;
      cpuSel_reg <= OVCSC_SEL_RST;
      for (int i = 0; i < 5; i++) begin
        ps_reg[i] <= OVCSC_PS_RST;
      end
      served_reg <= 1'b0;
      rdata_reg  <= 32'h0;
    end else begin
      level_reg  <= level_next;
      osc_reg    <= osc_next;
      cpuSel_reg <= cpuSel_next;
      for (int i = 0; i < 5; i++) begin
        ps_reg[i] <= ps_next[i];
      end
      served_reg <= served_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler counters
  // ----------------------------------------------------------------
  logic                   slowPrev_reg;
  logic                   fastPrev_reg;
  logic [OVCSC_CNT_W-1:0] slowCnt_reg;
  logic [OVCSC_CNT_W-1:0] slowCnt_next;
  logic [OVCSC_CNT_W-1:0] fastCnt_reg;
  logic [OVCSC_CNT_W-1:0] fastCnt_next;
  logic                   slowEdge;
  logic                   fastEdge;
  logic [4:0]             tick_next;
  logic [4:0]             tick_reg;

  // Slow section halts in sleep; fast section only with oscillator on
  assign slowEdge = slowOscillator & ~slowPrev_reg & ~sleep;
  assign fastEdge = fastOscillator & ~fastPrev_reg & osc_reg;

  // Divide per consumer and gate each one on its own enable
  always_comb begin
    logic [3:0] k;
    logic       src;
    k            = 4'h0;
    src          = 1'b0;
    slowCnt_next = slowEdge ? slowCnt_reg + 1'b1 : slowCnt_reg;
    fastCnt_next = fastEdge ? fastCnt_reg + 1'b1 : fastCnt_reg;
    for (int i = 0; i < 5; i++) begin
      src = ps_reg[i][OVCSC_PS_SRC];
      if (i < 2) begin
        k = src ? fastExp(ps_reg[i][2:0]) : {1'b0, ps_reg[i][2:0]};
      end else if (i == 2) begin
        k = {1'b0, ps_reg[i][2:0]} + 4'h1;
      end else begin
        k = {1'b0, ps_reg[i][2:0]};
      end
      tick_next[i] = ps_reg[i][OVCSC_PS_EN] &
                     (src ? fastEdge & divTap(fastCnt_reg, k)
                          : slowEdge & divTap(slowCnt_reg, k));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slowPrev_reg <= 1'b0;
      fastPrev_reg <= 1'b0;
      slowCnt_reg  <= '0;
      fastCnt_reg  <= '0;
      tick_reg     <= 5'h00;
    end else begin
      slowPrev_reg <= slowOscillator;
      fastPrev_reg <= fastOscillator;
      slowCnt_reg  <= slowCnt_next;
      fastCnt_reg  <= fastCnt_next;
      tick_reg     <= tick_next;
    end
  end

  // ----------------------------------------------------------------
  // CPU clock multiplexer
  // ----------------------------------------------------------------
  ovcsc_clk_mux uMux (
    .clk       (clk),
    .rst       (rst),
    .slowLevel (slowOscillator),
    .fastLevel (fastOscillator & osc_reg),
    .selFast   (cpuSel_reg),
    .cpuClock  (cpuClock),
    .onFast    (cpuOnFast)
  );

  // Outputs
  assign readdata             = rdata_reg;
  assign fastOscEnable        = osc_reg;
  assign coreLevelSel         = level_reg;
  assign coreRegulatorVoltage = ovcsc_level(level_reg);
  assign timer0Tick           = tick_reg[0];
  assign timer1Tick           = tick_reg[1];
  assign timer2Tick           = tick_reg[2];
  assign slowClockOut         = tick_reg[3];
  assign fastClockOut         = tick_reg[4];

endmodule

//--- src/ovcsc_pkg.sv
// Behaviour
// - Level field upper bit set gives 3.2 V, 01 gives 1.6 V, 00 gives 2.4 V.
// - Reset clears the level field, selecting 2.4 V.
// - Oscillator bit starts or stops the fast oscillator and reads back.
// - Reset clears the oscillator bit, fast oscillator stopped.
// - CPU select bit picks fast clock when one, slow when zero; readable.
// - Reset clears the CPU select bit, CPU runs from slow clock.
// - Slow prescaler section runs always except in sleep.
// - Prescaler divides both clocks with a ratio per consumer.
// - Divided clock is gated individually to each consumer.
package ovcsc_pkg;

  // ----------------------------------------------------------------
  // Register map (index, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] OVCSC_IDX_CTRL  = 16'hff01;
  localparam logic [15:0] OVCSC_IDX_PST0  = 16'hff02;
  localparam logic [15:0] OVCSC_IDX_PST1  = 16'hff03;
  localparam logic [15:0] OVCSC_IDX_PST2  = 16'hff04;
  localparam logic [15:0] OVCSC_IDX_SLOW_CLOCK_OUT = 16'hff05;
  localparam logic [15:0] OVCSC_IDX_FAST_CLOCK_OUT = 16'hff06;
  localparam logic [15:0] OVCSC_IDX_STAT  = 16'hff07;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int OVCSC_CTRL_LVL_LO  = 0;
  localparam int OVCSC_CTRL_LVL_HI  = 1;
  localparam int OVCSC_CTRL_OSC     = 2;
  localparam int OVCSC_CTRL_CPUSEL  = 3;
  localparam logic [1:0] OVCSC_LVL_RST = 2'h0;
  localparam logic       OVCSC_OSC_RST = 1'h0;
  localparam logic       OVCSC_SEL_RST = 1'h0;

  // ----------------------------------------------------------------
  // Prescaler register fields
  // ----------------------------------------------------------------
  localparam int OVCSC_PS_RATIO_LSB = 0;
  localparam int OVCSC_PS_SRC       = 3;
  localparam int OVCSC_PS_EN        = 4;
  localparam logic [4:0] OVCSC_PS_RST = 5'h00;

  // Status register fields
  localparam int OVCSC_ST_CPUFAST = 0;
  localparam int OVCSC_ST_OSCON   = 1;

  // Prescaler counter width (largest ratio 4096)
  localparam int OVCSC_CNT_W = 12;

  // Core regulator voltage levels
  typedef enum logic [1:0] {
    OVCSC_V1P6,
    OVCSC_V2P4,
    OVCSC_V3P2
  } ovcsc_volt_t;

  // Level field to voltage
  function automatic ovcsc_volt_t ovcsc_level(input logic [1:0] sel);
    if (sel[1]) begin
      return OVCSC_V3P2;
    end else if (sel[0]) begin
      return OVCSC_V1P6;
    end
    return OVCSC_V2P4;
  endfunction

endpackage

//--- src/ovcsc_clk_mux.sv
`timescale 1ns/1ps
module ovcsc_clk_mux
  import ovcsc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Source levels and request
  input  wire logic slowLevel,
  input  wire logic fastLevel,
  input  wire logic selFast,
  // CPU clock
  output logic      cpuClock,
  output logic      onFast
);

  logic curFast_reg;
  logic curFast_next;
  logic out_reg;
  logic out_next;

  // Switch only while both sources and the output sit low, so the
  // output low phase lasts at least two cycles across the change
  always_comb begin
    curFast_next = curFast_reg;
    if (selFast != curFast_reg && !slowLevel && !fastLevel
        && !out_reg) begin
      curFast_next = selFast;
    end
    out_next = curFast_next ? fastLevel : slowLevel;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      curFast_reg <= OVCSC_SEL_RST;
      out_reg     <= 1'b0;
    end else begin
      curFast_reg <= curFast_next;
      out_reg     <= out_next;
    end
  end

  assign cpuClock = out_reg;
  assign onFast   = curFast_reg;

endmodule

//--- verification/ovcsc_top_chk.sv
`timescale 1ns/1ps
module ovcsc_top_chk
  import ovcsc_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [17:0] address,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  // Sources
  input wire logic        slowOscillator,
  input wire logic        fastOscillator,
  input wire logic        sleep,
  // Watched outputs
  input wire logic        fastOscEnable,
  input wire logic [1:0]  coreLevelSel,
  input wire ovcsc_volt_t coreRegulatorVoltage,
  input wire logic        cpuClock,
  input wire logic        slowClockOut,
  input wire logic        fastClockOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic       ctrlWr;
  logic       selReg;
  logic       selNext;
  logic [5:0] cntReg;
  logic [5:0] cntNext;
  // Accepted control write
  assign ctrlWr = write && !waitrequest && byteenable[0]
                  && address == {OVCSC_IDX_CTRL, 2'h0};
  // Select shadow and settle count
  always_comb begin
    selNext = ctrlWr ? writedata[3] : selReg;
    cntNext = (cntReg == 6'h3f) ? cntReg : cntReg + 6'h01;
    if (ctrlWr) begin
      cntNext = 6'h00;
    end
  end
  // Shadow registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selReg <= 1'b0;
      cntReg <= 6'h00;
    end else begin
      selReg <= selNext;
      cntReg <= cntNext;
    end
  end
  // ----
  // Properties
  // ----
  AST_VOLT: assert property (coreRegulatorVoltage == (coreLevelSel[1] ?
    OVCSC_V3P2 : coreLevelSel[0] ? OVCSC_V1P6 : OVCSC_V2P4))
    else $error("level decode wrong");
  AST_RST: assert property ($fell(rst) |-> coreLevelSel == 2'h0
    && !fastOscEnable && !cpuClock) else $error("reset value wrong");
  AST_WR: assert property (ctrlWr |=> fastOscEnable == $past(writedata[2])
    && coreLevelSel == $past(writedata[1:0])) else $error("write lost");
  AST_HOLD: assert property (!ctrlWr |=> $stable(fastOscEnable)
    && $stable(coreLevelSel)) else $error("field moved");
  AST_SLOW: assert property (!selReg && cntReg == 6'h3f
    |-> cpuClock == $past(slowOscillator)) else $error("slow path");
  AST_FAST: assert property (selReg && fastOscEnable && cntReg == 6'h3f
    |-> cpuClock == $past(fastOscillator)) else $error("fast path");
  AST_GLITCH: assert property ($changed(cpuClock) |=> $stable(cpuClock))
    else $error("cpu clock runt");
  AST_PULSE: assert property (slowClockOut || fastClockOut |=>
    !slowClockOut && !fastClockOut) else $error("tick too long");
  AST_FOFF: assert property (!fastOscEnable [*4] |-> !fastClockOut)
    else $error("fast tick while off");
  AST_SLEEP: assert property (sleep [*4] |-> !slowClockOut)
    else $error("slow tick in sleep");
  cover property (ctrlWr && writedata[3]);
  cover property (fastClockOut);
  cover property (slowClockOut);
endmodule

bind ovcsc_top ovcsc_top_chk u_chk (.*);

//--- verification/ovcsc_top_tb.sv
`timescale 1ns/1ps
module ovcsc_top_tb
  import ovcsc_pkg::*;
;
  logic        clk, rst, read, write, sleep, slowOsc, fastOsc;
  logic        waitrequest, fastOscEnable, cpuClock;
  logic [17:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic [1:0]  coreLevelSel;
  ovcsc_volt_t volt;
  logic [4:0]  ticks;
  int          num_errors, checks_done, phase;
  int          codes [5] = '{1, 0, 2, 3, 0};

  ovcsc_top u_dut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .slowOscillator(slowOsc), .fastOscillator(fastOsc), .sleep(sleep),
    .fastOscEnable(fastOscEnable), .coreLevelSel(coreLevelSel),
    .coreRegulatorVoltage(volt), .cpuClock(cpuClock),
    .timer0Tick(ticks[0]), .timer1Tick(ticks[1]), .timer2Tick(ticks[2]),
    .slowClockOut(ticks[3]), .fastClockOut(ticks[4]));

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Sources: slow period 20 cycles, fast period 6
  always @(posedge clk) begin
    phase <= phase + 1;
    if (phase % 10 == 9) slowOsc <= ~slowOsc;
    if (phase % 3 == 2) fastOsc <= ~fastOsc;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Avalon transfer, held until waitrequest low
  task bus(input logic w, input logic [17:0] a, input logic [31:0] d,
           input logic [3:0] be);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task wr(input logic [15:0] i, input logic [31:0] d);
    bus(1'b1, {i, 2'h0}, d, 4'hf);
  endtask
  task rdchk(input logic [15:0] i, input logic [31:0] exp);
    bus(1'b0, {i, 2'h0}, 32'h0, 4'hf);
    check(rd, exp);
  endtask
  task cnt(input int i, input int n, input int exp);
    int k;
    k = 0;
    @(posedge clk); // Skip the sample computed before the new setting
    repeat (n) begin
      @(posedge clk);
      if (ticks[i] === 1'b1) k++;
    end
    check(32'(k), 32'(exp));
  endtask
  task t_levels;
    logic [1:0] c;
    for (int j = 0; j < 5; j++) begin
      c = 2'(codes[j]);
      wr(OVCSC_IDX_CTRL, {30'h0, c});
      repeat (20) @(posedge clk);
      check(32'(coreLevelSel), 32'(c));
      rdchk(OVCSC_IDX_CTRL, {30'h0, c});
      check(32'(volt), c[1] ? 32'(OVCSC_V3P2) : c[0] ? 32'(OVCSC_V1P6)
            : 32'(OVCSC_V2P4));
    end
  endtask
  task t_fast;
    wr(OVCSC_IDX_CTRL, 32'h4);
    rdchk(OVCSC_IDX_CTRL, 32'h4);
    check(32'(fastOscEnable), 32'h1);
    repeat (100) @(posedge clk);
    wr(OVCSC_IDX_CTRL, 32'hc);
    repeat (80) @(posedge clk);
    rdchk(OVCSC_IDX_STAT, 32'h3);
    wr(OVCSC_IDX_FAST_CLOCK_OUT, 32'h10);
    cnt(4, 120, 20);
    wr(OVCSC_IDX_FAST_CLOCK_OUT, 32'h11);
    cnt(4, 120, 10);
    wr(OVCSC_IDX_PST2, 32'h10);
    cnt(2, 120, 10);
    wr(OVCSC_IDX_PST0, 32'h08);
    wr(OVCSC_IDX_PST0, 32'h18);
    cnt(0, 120, 10);
    wr(OVCSC_IDX_FAST_CLOCK_OUT, 32'h0);
    wr(OVCSC_IDX_PST2, 32'h0);
    wr(OVCSC_IDX_PST0, 32'h0);
    cnt(4, 60, 0);
    wr(OVCSC_IDX_CTRL, 32'h4);
    wr(OVCSC_IDX_CTRL, 32'h0);
    repeat (80) @(posedge clk);
    rdchk(OVCSC_IDX_STAT, 32'h0);
    wr(OVCSC_IDX_FAST_CLOCK_OUT, 32'h10);
    cnt(4, 120, 0);
    wr(OVCSC_IDX_FAST_CLOCK_OUT, 32'h0);
  endtask
  task t_slow;
    wr(OVCSC_IDX_SLOW_CLOCK_OUT, 32'h10);
    cnt(3, 200, 10);
    wr(OVCSC_IDX_PST1, 32'h12);
    cnt(1, 160, 2);
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    cnt(3, 100, 0);
    sleep <= 1'b0;
    cnt(3, 200, 10);
    wr(OVCSC_IDX_SLOW_CLOCK_OUT, 32'h0);
    wr(OVCSC_IDX_PST1, 32'h0);
  endtask
  task t_refuse;
    wr(16'hff08, 32'h1f);
    rdchk(16'hff08, 32'h0);
    bus(1'b1, {OVCSC_IDX_CTRL, 2'h1}, 32'h3, 4'hf);
    bus(1'b1, {OVCSC_IDX_CTRL, 2'h0}, 32'h3, 4'he);
    rdchk(OVCSC_IDX_CTRL, 32'h0);
    wr(OVCSC_IDX_CTRL, 32'hf2);
    rdchk(OVCSC_IDX_CTRL, 32'h2);
  endtask
  task t_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk(OVCSC_IDX_CTRL, 32'h0);
    check(32'(volt), 32'(OVCSC_V2P4));
  endtask

  // Watchdog
  initial begin
    #(100 * 20000);
    num_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {rst, read, write, sleep, slowOsc, fastOsc} = 6'h20;
    {address, writedata, byteenable, phase} = '0;
    {num_errors, checks_done} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk(OVCSC_IDX_CTRL, 32'h0);
    rdchk(OVCSC_IDX_STAT, 32'h0);
    t_levels();
    t_fast();
    t_slow();
    t_refuse();
    t_reset();
    give_verdict();
  end
endmodule
